/* File: sssr_status_slave.sv */
// Slave that serves status byte reads and the pushed interrupt command.
`timescale 1ns/100ps
module sssr_status_slave (
   input logic sys_clk, // Hub clock, 20 MHz.
   input logic rst, // Synchronous reset, active high.
   input logic link_clk, // Link sampling clock.
   input logic scl_in, // Bus clock pin level.
   input logic sda_in, // Bus data pin level.
   output logic sda_out, // Data pin drive value, always low.
   output logic sda_oe, // Data pin pulled low while high.
   input logic [6:0] slave_addr, // Receive slave address setting.
   input logic [2:0] power_state, // System power state code.
   input logic [9:0] wdt_count, // Watchdog counter value.
   input logic cover_open_flag, // Chassis cover opened.
   input logic processor_dead, // Processor found dead.
   input logic second_timeout_flag, // Watchdog timed out twice.
   input logic alert_pin_disable, // Alert pin reporting disabled.
   input logic boot_flash_blank, // Boot flash read returned FFh.
   input logic thermal_alarm_in_n, // Thermal alarm pin, active low.
   input logic battery_low_in_n, // Battery low pin, active low.
   input logic smb_alert_in_n, // Alert pin level, active low.
   input logic flag_clear, // Clears the interrupt flag.
   output logic link_slave_interrupt_flag, // Sticky pushed-command flag.
   output logic system_mgmt_interrupt // Interrupt while flag set in S0.
);
   import sssr_pkg::*;

   // Link-domain reset, taken from the hub reset through the filter.
   logic link_rst;
   // Filtered bus pins and slave address in the link domain.
   logic scl_f;
   logic sda_f;
   logic [6:0] addr_f;
   // Previous filtered pin levels for edge detection.
   logic scl_d_r;
   logic sda_d_r;
   // Bus conditions derived from the filtered pins.
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   // Link protocol state and shift registers.
   sssr_state_t st_r, st_nxt;
   logic [3:0] bit_cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [7:0] rx_byte; // Byte completed by the current rising edge.
   logic [7:0] cmd_r, cmd_nxt; // Held command byte.
   logic cmd_seen_r, seen_nxt; // A command byte came in this message.
   logic rd_phase_r, rd_nxt; // Current address phase follows a restart.
   logic [7:0] tx_r, tx_nxt; // Outgoing data shift register.
   logic sda_oe_r, oe_nxt; // Open-drain enable flop.
   logic sda_out_r; // Open-drain value flop.
   logic req_tog_r, req_nxt; // Toggles when a new command is held.
   logic evt_tog_r, evt_nxt; // Toggles when a pushed command arrives.
   logic ack_f; // Hub answer toggle seen in the link domain.
   logic [7:0] rd_src; // Byte loaded for the read phase.
   // Hub-domain signals.
   logic req_f; // Request toggle seen in the hub domain.
   logic evt_f; // Event toggle seen in the hub domain.
   logic req_seen_r; // Last request served; also the answer toggle.
   logic evt_seen_r; // Last event handled.
   logic req_pulse; // New command to serve.
   logic evt_pulse; // New pushed command.
   logic in_s0; // System is in the working state.
   logic [2:0] pins_n_f; // Filtered active-low status pins.
   logic [7:0] rd_byte_r, rd_byte_nxt; // Selected status byte.
   logic [5:0] wdt_field; // Watchdog value limited to six bits.
   logic alert_bit; // Alert status as reported.
   logic flag_r, flag_nxt; // Interrupt status flag.
   logic smi_r; // Interrupt output flop.

   // Link reset follows the hub reset through three stages.
   sssr_pin_filter #(.W(1), .INIT(1'b1)) u_link_rst (
      .clk(link_clk), .rst(1'b0), .d(rst), .q(link_rst));

   // Bus pins are filtered on the link clock; idle level is high.
   sssr_pin_filter #(.W(2), .INIT({PIN_IDLE, PIN_IDLE})) u_bus_pins (
      .clk(link_clk), .rst(link_rst), .d({scl_in, sda_in}), .q({scl_f, sda_f}));

   // The address setting is quasi-static and is filtered into the link domain.
   sssr_pin_filter #(.W(7), .INIT(7'h00)) u_addr (
      .clk(link_clk), .rst(link_rst), .d(slave_addr), .q(addr_f));

   // The hub answer toggle crosses into the link domain.
   sssr_pin_filter #(.W(1), .INIT(1'b0)) u_ack (
      .clk(link_clk), .rst(link_rst), .d(req_seen_r), .q(ack_f));

   // Request and event toggles cross into the hub domain.
   sssr_pin_filter #(.W(2), .INIT(2'h0)) u_toggles (
      .clk(sys_clk), .rst(rst), .d({req_tog_r, evt_tog_r}), .q({req_f, evt_f}));

   // Active-low status pins are filtered in the hub domain.
   sssr_pin_filter #(.W(3), .INIT(PINS_N_RESET)) u_status_pins (
      .clk(sys_clk), .rst(rst), .d({smb_alert_in_n, battery_low_in_n, thermal_alarm_in_n}), .q(pins_n_f));

   // Edges and start and stop conditions from the filtered bus pins.
   assign scl_rise = scl_f & ~scl_d_r;
   assign scl_fall = ~scl_f & scl_d_r;
   assign start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
   assign stop_det = scl_f & scl_d_r & ~sda_d_r & sda_f;
   assign rx_byte = {sh_r[6:0], sda_f};

   // The held byte is used only once the hub has answered the last request.
   assign rd_src = (ack_f == req_tog_r) ? rd_byte_r : RESERVED_VALUE;

   // Next-state logic of the link protocol.
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = bit_cnt_r;
      sh_nxt = sh_r;
      cmd_nxt = cmd_r;
      seen_nxt = cmd_seen_r;
      rd_nxt = rd_phase_r;
      tx_nxt = tx_r;
      oe_nxt = sda_oe_r;
      req_nxt = req_tog_r;
      evt_nxt = evt_tog_r;
      if (stop_det) begin
         // A stop ends the message and frees the data line.
         st_nxt = ST_IDLE;
         oe_nxt = 1'b0;
         seen_nxt = 1'b0;
         rd_nxt = 1'b0;
      end else if (start_det) begin
         // A restart after a command byte opens the read phase.
         st_nxt = ST_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
         rd_nxt = cmd_seen_r & (st_r != ST_IDLE);
         seen_nxt = cmd_seen_r & (st_r != ST_IDLE);
      end else if (scl_rise) begin
         // Every rising edge shifts in one bit.
         sh_nxt = rx_byte;
         cnt_nxt = bit_cnt_r + 4'h1;
         case (st_r)
            ST_CMD: begin
               if (bit_cnt_r == BYTE_BITS - 4'h1) begin
                  // Hold the command and ask the hub for its byte.
                  cmd_nxt = rx_byte;
                  seen_nxt = 1'b1;
                  req_nxt = ~req_tog_r;
               end
            end
            ST_WDATA: begin
               // Pushed type 8 is passed on whatever the power state; other types are not.
               if (bit_cnt_r == BYTE_BITS - 4'h1 && cmd_r == PUSH_CMD_CODE &&
                   rx_byte == LINK_SLAVE_INTERRUPT_CMD) begin
                  evt_nxt = ~evt_tog_r;
               end
            end
            ST_RNACK: begin
               // Master answer sampled; wait for its stop.
               st_nxt = ST_WAIT;
            end
            default: begin
               // Other states only shift in and count bits.
            end
         endcase
      end else if (scl_fall) begin
         case (st_r)
            ST_ADDR: begin
               // The direction bit is ignored on a matching address.
               if (bit_cnt_r == BYTE_BITS) begin
                  if (sh_r[7:1] == addr_f) begin
                     st_nxt = ST_ADDR_ACK;
                     oe_nxt = 1'b1;
                  end else begin
                     st_nxt = ST_WAIT;
                  end
               end
            end
            ST_ADDR_ACK: begin
               cnt_nxt = 4'h0;
               if (rd_phase_r) begin
                  // Drive the first data bit as the acknowledge ends.
                  st_nxt = ST_RDATA;
                  tx_nxt = {rd_src[6:0], 1'b0};
                  oe_nxt = ~rd_src[7];
               end else begin
                  st_nxt = ST_CMD;
                  oe_nxt = 1'b0;
               end
            end
            ST_CMD: begin
               if (bit_cnt_r == BYTE_BITS) begin
                  st_nxt = ST_CMD_ACK;
                  oe_nxt = 1'b1;
               end
            end
            ST_WDATA: begin
               // Written bytes are acknowledged in any power state.
               if (bit_cnt_r == BYTE_BITS) begin
                  st_nxt = ST_WDATA_ACK;
                  oe_nxt = 1'b1;
               end
            end
            ST_CMD_ACK, ST_WDATA_ACK: begin
               st_nxt = ST_WDATA;
               cnt_nxt = 4'h0;
               oe_nxt = 1'b0;
            end
            ST_RDATA: begin
               if (bit_cnt_r == BYTE_BITS) begin
                  // Release the line for the master's not-acknowledge.
                  st_nxt = ST_RNACK;
                  oe_nxt = 1'b0;
               end else begin
                  tx_nxt = {tx_r[6:0], 1'b0};
                  oe_nxt = ~tx_r[7];
               end
            end
            default: begin
               // Idle, wait and answer states leave the line alone.
            end
         endcase
      end
   end

   // Link-domain registers.
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         st_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         sh_r <= 8'h00;
         cmd_r <= 8'h00;
         cmd_seen_r <= 1'b0;
         rd_phase_r <= 1'b0;
         tx_r <= 8'h00;
         sda_oe_r <= 1'b0;
         sda_out_r <= 1'b0;
         req_tog_r <= 1'b0;
         evt_tog_r <= 1'b0;
         scl_d_r <= PIN_IDLE;
         sda_d_r <= PIN_IDLE;
      end else begin
         st_r <= st_nxt;
         bit_cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         cmd_r <= cmd_nxt;
         cmd_seen_r <= seen_nxt;
         rd_phase_r <= rd_nxt;
         tx_r <= tx_nxt;
         sda_oe_r <= oe_nxt;
         sda_out_r <= 1'b0;
         req_tog_r <= req_nxt;
         evt_tog_r <= evt_nxt;
         scl_d_r <= scl_f;
         sda_d_r <= sda_f;
      end
   end

   assign sda_out = sda_out_r;
   assign sda_oe = sda_oe_r;

   // Hub-side decoding of toggles and power state.
   assign req_pulse = req_f ^ req_seen_r;
   assign evt_pulse = evt_f ^ evt_seen_r;
   assign in_s0 = (power_state == POWER_S0);

   // Status fields as they are reported.
   assign wdt_field = (|wdt_count[9:6]) ? WATCHDOG_SAT : wdt_count[5:0];
   assign alert_bit = alert_pin_disable | pins_n_f[2];

   // Byte selection by the held command; cmd_r is stable while req_pulse.
   assign rd_byte_nxt =
      (cmd_r == REG_CAPABILITY) ? CAPABILITY_VALUE :
      (cmd_r == REG_POWER_STATE) ? {5'h00, power_state} :
      (cmd_r == REG_WATCHDOG) ? {2'h0, wdt_field} :
      (cmd_r == REG_EVENT_FLAGS) ? {alert_bit, 3'h0, second_timeout_flag,
         processor_dead, ~pins_n_f[0], cover_open_flag} :
      (cmd_r == REG_PLATFORM) ? {6'h00, ~pins_n_f[1], boot_flash_blank} :
      RESERVED_VALUE;

   // A new event sets the flag in S0; a set wins over a clear.
   assign flag_nxt = (evt_pulse & in_s0) | (flag_r & ~flag_clear);

   // Hub-domain registers.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         req_seen_r <= 1'b0;
         evt_seen_r <= 1'b0;
         rd_byte_r <= RESERVED_VALUE;
         flag_r <= 1'b0;
         smi_r <= 1'b0;
      end else begin
         req_seen_r <= req_f;
         evt_seen_r <= evt_f;
         if (req_pulse) begin
            rd_byte_r <= rd_byte_nxt;
         end
         flag_r <= flag_nxt;
         smi_r <= flag_r & in_s0;
      end
   end

   assign link_slave_interrupt_flag = flag_r;
   assign system_mgmt_interrupt = smi_r;

   // A pushed command in S0 shows the flag on the next edge.
   property p_flag_set;
      @(posedge sys_clk) disable iff (rst) evt_pulse && in_s0 |=> link_slave_interrupt_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set in S0");
   // A pushed command while asleep leaves a clear flag clear.
   property p_flag_sleep;
      @(posedge sys_clk) disable iff (rst) evt_pulse && !in_s0 && !flag_r |=> !link_slave_interrupt_flag;
   endproperty
   a_flag_sleep: assert property (p_flag_sleep) else $error("flag set while asleep");
   // A held flag in S0 raises the interrupt on the next edge, even if S0 ends then.
   property p_smi_return;
      @(posedge sys_clk) disable iff (rst) flag_r && in_s0 && !flag_clear |=> system_mgmt_interrupt;
   endproperty
   a_smi_return: assert property (p_smi_return) else $error("interrupt missing in S0");
   // A captured command byte is the byte just shifted in.
   property p_cmd_capture;
      @(posedge link_clk) disable iff (link_rst)
         scl_rise && !stop_det && !start_det && st_r == ST_CMD && bit_cnt_r == 4'h7
         |=> cmd_r == $past(rx_byte) && req_tog_r != $past(req_tog_r);
   endproperty
   a_cmd_capture: assert property (p_cmd_capture) else $error("command byte lost");
   // Capability register serves zero.
   property p_capability;
      @(posedge sys_clk) disable iff (rst) req_pulse && cmd_r == REG_CAPABILITY |=> rd_byte_r == 8'h00;
   endproperty
   a_capability: assert property (p_capability) else $error("capability not zero");
   // Watchdog byte saturates above 3Fh.
   property p_wdt_sat;
      @(posedge sys_clk) disable iff (rst)
         req_pulse && cmd_r == REG_WATCHDOG && wdt_count > 10'h03f |=> rd_byte_r == 8'h3f;
   endproperty
   a_wdt_sat: assert property (p_wdt_sat) else $error("watchdog not saturated");
   // Event byte keeps reserved bits low and forces alert when disabled.
   property p_event_bits;
      @(posedge sys_clk) disable iff (rst)
         req_pulse && cmd_r == REG_EVENT_FLAGS |=> rd_byte_r[6:4] == 3'h0 && (rd_byte_r[7] || !$past(alert_pin_disable));
   endproperty
   a_event_bits: assert property (p_event_bits) else $error("event byte malformed");
   // Reserved registers read zero.
   property p_reserved;
      @(posedge sys_clk) disable iff (rst)
         req_pulse && (cmd_r == REG_RESERVED || cmd_r > REG_PLATFORM) |=> rd_byte_r == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved register not zero");
   // A matching address is acknowledged whatever its direction bit.
   property p_addr_ack;
      @(posedge link_clk) disable iff (link_rst)
         scl_fall && !start_det && st_r == ST_ADDR && bit_cnt_r == BYTE_BITS && sh_r[7:1] == addr_f
         |=> sda_oe && st_r == ST_ADDR_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
   // After the eighth data bit the line is released for the master.
   property p_read_release;
      @(posedge link_clk) disable iff (link_rst)
         scl_fall && !start_det && st_r == ST_RDATA && bit_cnt_r == BYTE_BITS |=> !sda_oe && st_r == ST_RNACK;
   endproperty
   a_read_release: assert property (p_read_release) else $error("data line not released");
   // The command byte is acknowledged on the next falling edge.
   property p_cmd_ack;
      @(posedge link_clk) disable iff (link_rst)
         scl_fall && !start_det && !stop_det && st_r == ST_CMD && bit_cnt_r == BYTE_BITS |=> sda_oe;
   endproperty
   a_cmd_ack: assert property (p_cmd_ack) else $error("command not acknowledged");
endmodule : sssr_status_slave

/* File: sssr_pkg.sv */
// Package of constants, states and functional notes for the status-read slave.
// Functional notes
// - Push type 8 in S0 sets flag.
// - Push type 8 asleep: acknowledge, flag stays.
// - Unserviced flag interrupts again back in S0.
// - Command byte selects returned status register.
// - Acknowledge bits 10, 19 and 29.
// - Drive data bits 30-37; master NACKs, stops.
// - Register 0 reads 00h capability.
// - Register 1 reports power state code.
// - Register 3 shows watchdog count, saturating 3Fh.
// - Register 4 bit 0 is cover open.
// - Register 4 bit 1 is thermal alarm.
// - Register 4 bit 2 is processor dead.
// - Register 4 bit 3 mirrors second timeout.
// - Register 4 bits 6:4 read zero.
// - Register 4 bit 7 alert pin or 1.
// - Register 5 bit 0 is blank flash.
// - Register 5 bit 1 is battery low.
// - First address match acknowledged whatever direction bit.
package sssr_pkg;
   // Register indices selected by the command byte.
   localparam logic [7:0] REG_CAPABILITY = 8'h00;
   localparam logic [7:0] REG_POWER_STATE = 8'h01;
   localparam logic [7:0] REG_RESERVED = 8'h02;
   localparam logic [7:0] REG_WATCHDOG = 8'h03;
   localparam logic [7:0] REG_EVENT_FLAGS = 8'h04;
   localparam logic [7:0] REG_PLATFORM = 8'h05;
   // Fixed read values and saturation limit.
   localparam logic [7:0] CAPABILITY_VALUE = 8'h00;
   localparam logic [5:0] WATCHDOG_SAT = 6'h3f;
   localparam logic [7:0] RESERVED_VALUE = 8'h00;
   // Power state code for the working state.
   localparam logic [2:0] POWER_S0 = 3'h0;
   // Write command code that carries a pushed command type.
   localparam logic [7:0] PUSH_CMD_CODE = 8'h00;
   // Pushed command type that raises the link interrupt flag.
   localparam logic [7:0] LINK_SLAVE_INTERRUPT_CMD = 8'h08;
   // Bit count of one byte on the wire, and of an address plus direction.
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Reset values of the bus pin filters and the active-low pin filters.
   localparam logic PIN_IDLE = 1'b1;
   localparam logic [2:0] PINS_N_RESET = 3'h7;
   // Link-side protocol states.
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RNACK,
      ST_WAIT
   } sssr_state_t;
endpackage : sssr_pkg

/* File: sssr_pin_filter.sv */
// Three-stage input filter that takes a level once two late stages agree.
`timescale 1ns/100ps
module sssr_pin_filter #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input logic clk, // Sampling clock.
   input logic rst, // Synchronous reset, active high.
   input logic [W-1:0] d, // Input from another domain or a pin.
   output logic [W-1:0] q // Filtered level.
);
   logic [W-1:0] s1_r; // First stage, read only by the second.
   logic [W-1:0] s2_r; // Second stage.
   logic [W-1:0] s3_r; // Third stage.
   logic [W-1:0] q_r; // Accepted level.
   logic [W-1:0] q_nxt; // Next accepted level.

   // Each bit follows the stages only where the second and third agree.
   assign q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
   assign q = q_r;

   // Sampling chain with a known value after reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         q_r <= INIT;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end
endmodule : sssr_pin_filter

/* File: sssr_master_model.sv */
// Bus master model that runs byte reads and pushed writes against the status slave.
`timescale 1ns/100ps
module sssr_master_model #(
   parameter int QTR = 10
) (
   input logic link_clk, // Timing reference for bus phases.
   input logic sda_in, // Data wire level.
   output logic scl_out, // Bus clock wire, still between frames.
   output logic sda_oe // Pulls the data wire low while high.
);
   // Clock idles driven high and data idles released, so the pull-up holds it high.
   initial begin
      scl_out = 1'b1;
      sda_oe = 1'b0;
   end
   // Waits one quarter of a bit time.
   task automatic qtr();
      repeat (QTR) @(posedge link_clk);
   endtask : qtr
   // One bit: data changes a quarter after the clock falls, sampled mid-high.
   task automatic bit_io(input logic b, output logic r);
      qtr();
      sda_oe <= ~b;
      qtr();
      scl_out <= 1'b1;
      qtr();
      r = sda_in;
      qtr();
      scl_out <= 1'b0;
   endtask : bit_io
   // Eight bits MSB first, then a released ninth bit whose level is returned.
   task automatic byte_io(input logic [7:0] v, output logic nak, output logic [7:0] rv);
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], rv[i]);
      end
      bit_io(1'b1, nak);
   endtask : byte_io
   // Start or repeated start: data falls while the clock is high.
   task automatic start_bit();
      qtr();
      sda_oe <= 1'b0;
      qtr();
      scl_out <= 1'b1;
      qtr();
      sda_oe <= 1'b1;
      qtr();
      scl_out <= 1'b0;
   endtask : start_bit
   // Stop: data rises while the clock is high, then both stay released.
   task automatic stop_bit();
      qtr();
      sda_oe <= 1'b1;
      qtr();
      scl_out <= 1'b1;
      qtr();
      sda_oe <= 1'b0;
      qtr();
   endtask : stop_bit
   // Byte read: address, command, restart, address with read, data, not-acknowledge, stop.
   task automatic read_reg(input logic [6:0] a, input logic dir, input logic [7:0] cmd,
                           output logic [7:0] d, output logic [2:0] nak);
      logic [7:0] t;
      logic x;
      start_bit();
      byte_io({a, dir}, nak[2], t);
      byte_io(cmd, nak[1], t);
      start_bit();
      byte_io({a, 1'b1}, nak[0], t);
      byte_io(8'hff, x, d);
      stop_bit();
   endtask : read_reg
   // Write of one command byte and one data byte.
   task automatic write_reg(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] data,
                            output logic [2:0] nak);
      logic [7:0] t;
      start_bit();
      byte_io({a, 1'b0}, nak[2], t);
      byte_io(cmd, nak[1], t);
      byte_io(data, nak[0], t);
      stop_bit();
   endtask : write_reg
endmodule : sssr_master_model

/* File: sssr_status_slave_tb.sv */
// Self-checking testbench of the status-read slave with a bus master model.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module sssr_status_slave_tb;
   import sssr_pkg::*;
   localparam logic [6:0] ADDR = 7'h2c; // Receive address under test.
   logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, scl_in, m_oe, sda_out, sda_oe;
   logic [6:0] slave_addr = ADDR;
   logic [2:0] power_state = 3'h0;
   logic [9:0] wdt_count = 10'h000;
   logic cover_open_flag = 1'b0, processor_dead = 1'b0, second_timeout_flag = 1'b0;
   logic alert_pin_disable = 1'b0, boot_flash_blank = 1'b0, thermal_alarm_in_n = 1'b1;
   logic battery_low_in_n = 1'b1, smb_alert_in_n = 1'b1, flag_clear = 1'b0;
   logic link_slave_interrupt_flag, system_mgmt_interrupt;
   logic [15:0] seed = 16'h001b; // Random source state.
   logic [2:0] ps_tab [4] = '{3'h0, 3'h3, 3'h4, 3'h5}; // Legal power codes.
   logic [9:0] corner [4] = '{10'h03e, 10'h03f, 10'h040, 10'h3ff}; // Saturation edges.
   int err_total = 0, n_checks = 0;
   // Open-drain data wire with a pull-up.
   wire sda_in = ~m_oe & (sda_oe ? sda_out : 1'b1);
   // Hub clock and an unrelated link clock.
   always #25 sys_clk = ~sys_clk;
   always #7.5 link_clk = ~link_clk;
   sssr_status_slave dut (.sys_clk, .rst, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .slave_addr,
      .power_state, .wdt_count, .cover_open_flag, .processor_dead, .second_timeout_flag,
      .alert_pin_disable, .boot_flash_blank, .thermal_alarm_in_n, .battery_low_in_n,
      .smb_alert_in_n, .flag_clear, .link_slave_interrupt_flag, .system_mgmt_interrupt);
   sssr_master_model u_master (.link_clk(link_clk), .sda_in(sda_in), .scl_out(scl_in), .sda_oe(m_oe));
   // Next state of the random source.
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Byte the slave should return for a command code.
   function automatic logic [7:0] exp_byte(input logic [7:0] c);
      case (c)
         REG_POWER_STATE: return {5'h00, power_state};
         REG_WATCHDOG: return {2'h0, (wdt_count > 10'h03f) ? 6'h3f : wdt_count[5:0]};
         REG_EVENT_FLAGS: return {alert_pin_disable | smb_alert_in_n, 3'h0, second_timeout_flag,
                                  processor_dead, ~thermal_alarm_in_n, cover_open_flag};
         REG_PLATFORM: return {6'h00, ~battery_low_in_n, boot_flash_blank};
         default: return 8'h00;
      endcase
   endfunction : exp_byte
   // Draws new status inputs at a hub clock edge.
   task automatic rand_inputs(input int i);
      @(posedge sys_clk);
      seed = lfsr(seed);
      power_state <= ps_tab[seed[1:0]];
      wdt_count <= (i < 4) ? corner[i[1:0]] : seed[15:6];
      {cover_open_flag, processor_dead, second_timeout_flag, alert_pin_disable} <= seed[5:2];
      {boot_flash_blank, thermal_alarm_in_n, battery_low_in_n, smb_alert_in_n} <= seed[9:6];
   endtask : rand_inputs
   // One byte read with its acknowledges and data compared.
   task automatic do_read(input logic [6:0] a, input logic dir, input logic [7:0] cmd, input logic hit);
      logic [7:0] d;
      logic [2:0] nak;
      repeat (6) @(posedge sys_clk);
      u_master.read_reg(a, dir, cmd, d, nak);
      `CHK("read acks", hit ? 3'h0 : 3'h7, nak)
      `CHK("read data", hit ? exp_byte(cmd) : 8'hff, d)
   endtask : do_read
   // Pushed write of one command type, then the flag compared.
   task automatic push(input logic [7:0] data, input logic exp_flag);
      logic [2:0] nak;
      u_master.write_reg(ADDR, PUSH_CMD_CODE, data, nak);
      repeat (10) @(posedge sys_clk);
      `CHK("push acks", 3'h0, nak)
      `CHK("flag", exp_flag, link_slave_interrupt_flag)
   endtask : push
   // Prints the verdict and ends the run.
   task automatic conclude();
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // Main sequence: reset, register reads, pushed commands.
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (20) @(posedge sys_clk);
      for (int i = 0; i < 24; i++) begin
         // The first reads hit the saturation corners, then every low register in turn.
         rand_inputs(i);
         do_read(ADDR, 1'b0, (i < 4) ? REG_WATCHDOG : (i < 12) ? 8'(i - 4) : seed[15:8], 1'b1);
      end
      do_read(ADDR, 1'b1, REG_EVENT_FLAGS, 1'b1);
      do_read(ADDR ^ 7'h01, 1'b0, REG_POWER_STATE, 1'b0);
      @(posedge sys_clk);
      power_state <= POWER_S0;
      push(8'h07, 1'b0);
      push(LINK_SLAVE_INTERRUPT_CMD, 1'b1);
      `CHK("smi in S0", 1'b1, system_mgmt_interrupt)
      power_state <= 3'h3;
      repeat (8) @(posedge sys_clk);
      `CHK("smi asleep", 1'b0, system_mgmt_interrupt)
      power_state <= POWER_S0;
      repeat (8) @(posedge sys_clk);
      `CHK("smi back in S0", 1'b1, system_mgmt_interrupt)
      flag_clear <= 1'b1;
      @(posedge sys_clk);
      flag_clear <= 1'b0;
      power_state <= 3'h5;
      repeat (4) @(posedge sys_clk);
      `CHK("flag cleared", 1'b0, link_slave_interrupt_flag)
      push(LINK_SLAVE_INTERRUPT_CMD, 1'b0);
      conclude();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #1200000;
      err_total++;
      conclude();
   end
endmodule : sssr_status_slave_tb
